// file: src/fsa_pkg.sv
// Constants, types and helper functions for the fan status alarm monitor.
package fsa_pkg;

	// Sizes of the fan array, the alarm set and the report code.
	localparam int NFANS         = 18;
	localparam int NALM          = 7;
	localparam int CODES_PER_FAN = 11;

	// Bit positions in the status word (low byte, counted from bit 0).
	localparam int BIT_BLOCKED = 7;
	localparam int BIT_HALL    = 6;
	localparam int BIT_MOTHOT  = 5;
	localparam int BIT_FANBAD  = 4;
	localparam int BIT_COMM    = 3;
	localparam int BIT_SPARE   = 1;
	localparam int BIT_PHASE   = 0;
	localparam logic [15:0] SPARE_MASK = 16'h0002;

	// Alarm slots; slot k reports code offset CODE_OFS_FIRST + k in its fan group.
	localparam int A_BLOCKED = 0;
	localparam int A_HALL    = 1;
	localparam int A_MOTHOT  = 2;
	localparam int A_FANBAD  = 3;
	localparam int A_COMM    = 4;
	localparam int A_STAGE   = 5;
	localparam int A_PHASE   = 6;
	localparam int BIT_STAGE = 2;
	localparam logic [7:0] CODE_OFS_FIRST = 8'h05;
	localparam logic [7:0] CODE_NONE      = 8'h00;
	localparam logic [7:0] CODE_MAX       = 8'hc6;

	// Register byte offsets.
	localparam logic [7:0] REG_COUNT = 8'h00;
	localparam logic [7:0] REG_ISTAT = 8'h04;
	localparam logic [7:0] REG_IMASK = 8'h08;
	localparam logic [7:0] REG_CODE  = 8'h0c;
	localparam logic [7:0] REG_SUM   = 8'h10;
	localparam logic [7:0] REG_WORD0 = 8'h40;
	localparam logic [7:0] REG_ALM0  = 8'ha0;

	// Reset values.
	localparam logic [4:0]  COUNT_RST = 5'h00;
	localparam logic [17:0] MASK_RST  = 18'h00000;

	// Alarm carriers.
	typedef logic [NALM-1:0] fsa_alm_t;
	typedef logic [NFANS-1:0][NALM-1:0] fsa_alm_vec_t;

	// State of the top module.
	typedef struct packed {
		logic                        ack;
		logic [31:0]                 rdat;
		logic [4:0]                  count;
		logic [NFANS-1:0][15:0]      word;
		fsa_alm_vec_t                alm;
		logic                        gen;
	} fsa_top_st_t;

	// State of the interrupt block.
	typedef struct packed {
		fsa_alm_vec_t      prev;
		logic [NFANS-1:0]  stat;
		logic [NFANS-1:0]  mask;
		logic              irq;
	} fsa_irq_st_t;

	// Maps a status word to the alarm slots; unlisted bits fall out here.
	function automatic fsa_alm_t word_alarms(input logic [15:0] w);
		fsa_alm_t a;
		a = '0;
		a[A_BLOCKED] = w[BIT_BLOCKED];
		a[A_HALL]    = w[BIT_HALL];
		a[A_MOTHOT]  = w[BIT_MOTHOT];
		a[A_FANBAD]  = w[BIT_FANBAD];
		a[A_COMM]    = w[BIT_COMM];
		a[A_STAGE]   = w[BIT_STAGE];
		a[A_PHASE]   = w[BIT_PHASE];
		return a;
	endfunction : word_alarms

	// Report code of one alarm slot of one fan, fan index counted from zero.
	function automatic logic [7:0] fan_code(input int fan, input int slot);
		return 8'(CODES_PER_FAN * fan + slot) + CODE_OFS_FIRST;
	endfunction : fan_code

	// Expands Wishbone byte selects into a bit mask.
	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : sel_mask

endpackage : fsa_pkg

// file: src/fsa_code_enc.sv
// Encoder that reports the lowest active fan alarm as a numeric code.
`timescale 1ns/1ps
module fsa_code_enc (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Alarm flags of all fans.
	input  wire fsa_pkg::fsa_alm_vec_t alm_i,
	// Registered report code.
	output logic [7:0]                code_o
);

	logic [7:0] code_r;
	logic [7:0] code_nxt;

	// Picks the first active slot, lowest fan first, zero when none is set.
	always_comb begin
		code_nxt = fsa_pkg::CODE_NONE;
		for (int f = fsa_pkg::NFANS - 1; f >= 0; f--) begin
			for (int k = fsa_pkg::NALM - 1; k >= 0; k--) begin
				if (alm_i[f][k]) begin
					code_nxt = fsa_pkg::fan_code(f, k); // [R11]
				end
			end
		end
	end

	// Registers the code.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_r <= fsa_pkg::CODE_NONE;
		end else begin
			code_r <= code_nxt;
		end
	end

	assign code_o = code_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	code_idle_a: assert property (alm_i == '0 |=> code_o == fsa_pkg::CODE_NONE) // [R11]
		else $error("Code not zero without alarm.");
	code_first_a: assert property (alm_i[0][0] |=> code_o == 8'h05) // [R11]
		else $error("Fan one blocked code wrong.");
	code_last_a: assert property (alm_i[17] == 7'h40 && alm_i[16:0] == '0 |=> code_o == 8'hc6) // [R11]
		else $error("Last fan phase code wrong.");

endmodule : fsa_code_enc

// file: src/fsa_irq.sv
// Sticky per-fan alarm events, mask and level interrupt.
`timescale 1ns/1ps
module fsa_irq (
	// Clock and reset.
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// Alarm flags of all fans.
	input  wire fsa_pkg::fsa_alm_vec_t alm_i,
	// Register writes; data arrives unmasked, with its byte select mask beside it.
	input  wire logic                  stat_clr_i,
	input  wire logic                  mask_wr_i,
	input  wire logic [17:0]           wdat_i,
	input  wire logic [17:0]           wmask_i,
	// Register contents and interrupt.
	output logic [17:0]                stat_o,
	output logic [17:0]                mask_o,
	output logic                       irq_o
);

	fsa_pkg::fsa_irq_st_t s;
	fsa_pkg::fsa_irq_st_t n;
	logic [17:0]          ev;

	// A fan event is any alarm slot of that fan rising; set beats clear.
	always_comb begin
		n = s;
		for (int f = 0; f < fsa_pkg::NFANS; f++) begin
			ev[f] = |(alm_i[f] & ~s.prev[f]);
		end
		n.prev = alm_i;
		n.stat = (s.stat & ~(stat_clr_i ? (wdat_i & wmask_i) : 18'h00000)) | ev;
		if (mask_wr_i) begin
			n.mask = (s.mask & ~wmask_i) | (wdat_i & wmask_i);
		end
		n.irq = |(s.stat & s.mask);
	end

	// Registers the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '{prev: '0, stat: '0, mask: fsa_pkg::MASK_RST, irq: 1'b0};
		end else begin
			s <= n;
		end
	end

	assign stat_o = s.stat;
	assign mask_o = s.mask;
	assign irq_o  = s.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	set_wins_a: assert property (ev[0] && stat_clr_i && wdat_i[0] |=> stat_o[0])
		else $error("Event lost under clear.");
	irq_level_a: assert property (##1 irq_o == $past(|(stat_o & mask_o)))
		else $error("Interrupt level wrong.");

endmodule : fsa_irq

// file: src/fsa_top.sv
// Fan status alarm monitor with a classic Wishbone register slave.
//
// Operation
// R1 - Evaluate a fan's alarms only while fan count is at least its index.
// R2 - Motor blocked alarm follows status bit eight while the fan counts.
// R3 - Hall sensor error alarm follows status bit seven.
// R4 - Motor overheating alarm follows status bit six.
// R5 - General fan fault alarm follows status bit five.
// R6 - Communication error alarm follows status bit four.
// R7 - Output stage overheating alarm follows status bit three.
// R8 - Phase failure alarm follows status bit one.
// R9 - Any active fan alarm drives the general alarm output.
// R10 - Unassigned low byte bits, like bit two, never affect alarms.
// R11 - Active alarm reported as code eleven per fan, offset one; zero none. Code uses offset five.
//
// Software writes the polled status word of each fan into its register; the
// monitor gates, decodes and reports the alarms.
`timescale 1ns/1ps
module fsa_top (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Alarm outputs.
	output logic             gen_alarm_o,
	output logic      [7:0]  alarm_code_o,
	output logic             irq_o
);

	fsa_pkg::fsa_top_st_t s;
	fsa_pkg::fsa_top_st_t n;

	logic        req;
	logic        wr;
	logic [31:0] wm;
	logic [5:0]  widx;
	logic        any_alm;
	logic        stat_clr;
	logic        mask_wr;
	logic [17:0] stat;
	logic [17:0] mask;
	fsa_pkg::fsa_alm_t slot_or;

	// Decodes a new bus request; the pulse stops a held request acting twice.
	assign req      = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr       = req & wb_we_i;
	assign wm       = fsa_pkg::sel_mask(wb_sel_i);
	assign widx     = wb_adr_i[7:2];
	assign stat_clr = wr & (wb_adr_i == fsa_pkg::REG_ISTAT);
	assign mask_wr  = wr & (wb_adr_i == fsa_pkg::REG_IMASK);
	assign any_alm  = |s.alm;

	// Collects each slot over all fans for the summary register.
	always_comb begin
		slot_or = '0;
		for (int f = 0; f < fsa_pkg::NFANS; f++) begin
			slot_or = slot_or | s.alm[f];
		end
	end

	// Next state: bus answer, register writes, alarm evaluation.
	always_comb begin
		n = s;
		n.ack = req;
		n.rdat = 32'h00000000;
		// Register writes take effect in the cycle the request is taken.
		if (wr) begin
			if (wb_adr_i == fsa_pkg::REG_COUNT && wb_sel_i[0]) begin
				n.count = wb_dat_i[4:0];
			end
			for (int f = 0; f < fsa_pkg::NFANS; f++) begin
				if (widx == 6'(int'(fsa_pkg::REG_WORD0[7:2]) + f)) begin
					n.word[f] = (s.word[f] & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
				end
			end
		end
		// Read data; unmapped addresses and writes answer zero.
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				fsa_pkg::REG_COUNT: n.rdat = {27'h0000000, s.count};
				fsa_pkg::REG_ISTAT: n.rdat = {14'h0000, stat};
				fsa_pkg::REG_IMASK: n.rdat = {14'h0000, mask};
				fsa_pkg::REG_CODE:  n.rdat = {24'h000000, alarm_code_o};
				fsa_pkg::REG_SUM:   n.rdat = {17'h00000, slot_or, 7'h00, s.gen};
				default: begin
					for (int f = 0; f < fsa_pkg::NFANS; f++) begin
						if (widx == 6'(int'(fsa_pkg::REG_WORD0[7:2]) + f)) begin
							n.rdat = {16'h0000, s.word[f]};
						end
						if (widx == 6'(int'(fsa_pkg::REG_ALM0[7:2]) + f)) begin
							n.rdat = {25'h0000000, s.alm[f]};
						end
					end
				end
			endcase
		end
		// Gated decode; fans beyond the count are held released.
		for (int f = 0; f < fsa_pkg::NFANS; f++) begin
			if (s.count >= 5'(f + 1)) begin // [R1]
				n.alm[f] = fsa_pkg::word_alarms(s.word[f]); // [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R10]
			end else begin
				n.alm[f] = '0; // [R1]
			end
		end
		// General alarm is the OR of every fan's registered alarms.
		n.gen = any_alm; // [R9]
	end

	// Registers the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '{ack: 1'b0, rdat: '0, count: fsa_pkg::COUNT_RST, word: '0,
			       alm: '0, gen: 1'b0};
		end else begin
			s <= n;
		end
	end

	// Report code encoder.
	fsa_code_enc u_enc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.alm_i  (s.alm),
		.code_o (alarm_code_o)
	);

	// Interrupt status and mask.
	fsa_irq u_irq (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.alm_i      (s.alm),
		.stat_clr_i (stat_clr),
		.mask_wr_i  (mask_wr),
		.wdat_i     (wb_dat_i[17:0]),
		.wmask_i    (wm[17:0]),
		.stat_o     (stat),
		.mask_o     (mask),
		.irq_o      (irq_o)
	);

	// Outputs come straight from the state flops.
	assign wb_ack_o    = s.ack;
	assign wb_dat_o    = s.rdat;
	assign gen_alarm_o = s.gen;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A taken request and its one-cycle answer.
	sequence new_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse_s;
		##1 wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence wr_count_s;
		new_req_s and (wb_we_i && wb_adr_i == fsa_pkg::REG_COUNT && wb_sel_i[0]);
	endsequence

	bus_answer_a: assert property (new_req_s |-> ack_pulse_s)
		else $error("Ack not a single pulse after request.");
	count_write_a: assert property (wr_count_s |=> wb_ack_o && s.count == $past(wb_dat_i[4:0]))
		else $error("Fan count not written.");
	unmapped_read_a: assert property (new_req_s and (!wb_we_i && wb_adr_i == 8'h30)
		|=> wb_dat_o == 32'h00000000)
		else $error("Unmapped read not zero.");
	count_read_a: assert property (new_req_s and (!wb_we_i && wb_adr_i == fsa_pkg::REG_COUNT)
		|=> wb_dat_o == {27'h0000000, $past(s.count)})
		else $error("Fan count read back wrong.");
	// With no fans counted every alarm is released, so the general alarm drops.
	no_fans_a: assert property (s.count == 5'h00 |-> ##2 !gen_alarm_o) // [R1] [R9]
		else $error("General alarm kept with no fans counted.");
	gen_alarm_a: assert property (##1 gen_alarm_o == $past(any_alm)) // [R9]
		else $error("General alarm does not follow fan alarms.");

	// Per-fan checks of gating and bit mapping.
	for (genvar g = 0; g < fsa_pkg::NFANS; g++) begin : g_chk
		localparam logic [4:0] FAN_N = 5'(g + 1);
		gate_off_a: assert property (s.count < FAN_N |=> s.alm[g] == '0) // [R1]
			else $error("Alarm kept beyond fan count.");
		blocked_map_a: assert property (s.count >= FAN_N // [R2]
			|=> s.alm[g][fsa_pkg::A_BLOCKED] == $past(s.word[g][7]))
			else $error("Motor blocked alarm wrong.");
		hall_map_a: assert property (s.count >= FAN_N // [R3]
			|=> s.alm[g][fsa_pkg::A_HALL] == $past(s.word[g][6]))
			else $error("Hall sensor alarm wrong.");
		motor_hot_a: assert property (s.count >= FAN_N // [R4]
			|=> s.alm[g][fsa_pkg::A_MOTHOT] == $past(s.word[g][5]))
			else $error("Motor overheating alarm wrong.");
		fan_bad_a: assert property (s.count >= FAN_N // [R5]
			|=> s.alm[g][fsa_pkg::A_FANBAD] == $past(s.word[g][4]))
			else $error("Fan fault alarm wrong.");
		comm_err_a: assert property (s.count >= FAN_N // [R6]
			|=> s.alm[g][fsa_pkg::A_COMM] == $past(s.word[g][3]))
			else $error("Communication alarm wrong.");
		stage_hot_a: assert property (s.count >= FAN_N // [R7]
			|=> s.alm[g][fsa_pkg::A_STAGE] == $past(s.word[g][2]))
			else $error("Output stage alarm wrong.");
		phase_fail_a: assert property (s.count >= FAN_N // [R8]
			|=> s.alm[g][fsa_pkg::A_PHASE] == $past(s.word[g][0]))
			else $error("Phase failure alarm wrong.");
		spare_bit_a: assert property ( // [R10]
			((s.word[g] ^ $past(s.word[g])) == fsa_pkg::SPARE_MASK) && $stable(s.count)
			|=> $stable(s.alm[g]))
			else $error("Spare status bit changed an alarm.");
	end

endmodule : fsa_top

// file: tb/fsa_fan_model.sv
// Behavioural fan drive that turns a reported fault into its status word.
`timescale 1ns/1ps
module fsa_fan_model (
	// Fault reported: 0 to 6 alarm slots, 7 spare bits only, else healthy.
	input  wire logic [3:0]  fault_i,
	// Status word as polled from the drive.
	output logic      [15:0] word_o
);
	// Low byte bits are numbered from one, so bit eight is word bit 7.
	always_comb begin
		case (fault_i)
			4'h0: word_o = 16'h0080;
			4'h1: word_o = 16'h0040;
			4'h2: word_o = 16'h0020;
			4'h3: word_o = 16'h0010;
			4'h4: word_o = 16'h0008;
			4'h5: word_o = 16'h0004;
			4'h6: word_o = 16'h0001;
			4'h7: word_o = 16'hff02;
			default: word_o = 16'h0000;
		endcase
	end
endmodule : fsa_fan_model

// file: tb/fsa_top_bench.sv
// Self-checking bench for the fan status alarm monitor.
`timescale 1ns/1ps
module fsa_top_bench;
	// Clock, reset, bus and alarm signals.
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] q;
	logic [31:0] rdat;
	logic        ack;
	logic        gen;
	logic        irq;
	logic [7:0]  code;
	logic [3:0]  fault;
	logic [15:0] fword;
	int          err_total;
	int          cmp_count;
	int          cyc_n;
	localparam logic [7:0] RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'ha0, 8'h30};

	fsa_top i_fsa_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.gen_alarm_o(gen), .alarm_code_o(code), .irq_o(irq)
	);
	fsa_fan_model i_fsa_fan_model (.fault_i(fault), .word_o(fword));

	// Free running 200 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// Compares one value and reports a mismatch.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One classic Wishbone cycle; read data lands in q.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk("wb_ack", 32'h1, 32'(ack));
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	// Lets the alarm, code and interrupt pipeline land.
	task automatic settle;
		repeat (4) @(posedge clk_i);
	endtask : settle

	// Loads a fan word with the drive model's word for a fault.
	task automatic put(input logic [7:0] a, input logic [3:0] f);
		fault <= f;
		@(posedge clk_i);
		wb(1'b1, a, 32'(fword));
		settle;
	endtask : put

	// Reset values of outputs and registers, unmapped address reads zero.
	task automatic t_reset;
		chk("gen_alarm", 32'h0, 32'(gen));
		chk("alarm_code", 32'h0, 32'(code));
		chk("irq", 32'h0, 32'(irq));
		foreach (RA[i]) begin
			wb(1'b0, RA[i], 32'h0);
			chk("reg_reset", 32'h0, q);
		end
		$display("t_reset finished");
	endtask : t_reset

	// Every alarm slot of fan 1 raised and released in turn.
	task automatic t_slots;
		wb(1'b1, 8'h00, 32'd18);
		for (int k = 0; k < 7; k++) begin
			put(8'h40, 4'(k));
			chk("gen_alarm", 32'h1, 32'(gen));
			chk("alarm_code", 32'(5 + k), 32'(code));
			wb(1'b0, 8'ha0, 32'h0);
			chk("fan1_alarms", 32'h1 << k, q);
			wb(1'b0, 8'h10, 32'h0);
			chk("summary", (32'h100 << k) | 32'h1, q);
			put(8'h40, 4'hf);
			chk("gen_alarm", 32'h0, 32'(gen));
			chk("alarm_code", 32'h0, 32'(code));
		end
		$display("t_slots finished");
	endtask : t_slots

	// Spare low byte bit and high byte never raise an alarm.
	task automatic t_spare;
		wb(1'b1, 8'h44, 32'h00000002);
		settle;
		chk("gen_alarm", 32'h0, 32'(gen));
		put(8'h44, 4'h7);
		chk("gen_alarm", 32'h0, 32'(gen));
		wb(1'b0, 8'ha4, 32'h0);
		chk("fan2_alarms", 32'h0, q);
		put(8'h44, 4'hf);
		$display("t_spare finished");
	endtask : t_spare

	// Fan 18 alarm gated by the fan count at its boundary.
	task automatic t_count;
		wb(1'b1, 8'h00, 32'd17);
		put(8'h84, 4'h0);
		chk("gen_alarm", 32'h0, 32'(gen));
		wb(1'b1, 8'h00, 32'd18);
		settle;
		chk("alarm_code", 32'd192, 32'(code));
		wb(1'b1, 8'h00, 32'd17);
		settle;
		chk("gen_alarm", 32'h0, 32'(gen));
		wb(1'b1, 8'h00, 32'd18);
		put(8'h84, 4'hf);
		$display("t_count finished");
	endtask : t_count

	// Sticky event of fan 4, masked, unmasked and cleared by writing one.
	task automatic t_irq;
		wb(1'b1, 8'h04, 32'h3ffff);
		put(8'h4c, 4'h4);
		wb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h8, q);
		chk("irq", 32'h0, 32'(irq));
		wb(1'b1, 8'h08, 32'h8);
		settle;
		chk("irq", 32'h1, 32'(irq));
		put(8'h4c, 4'hf);
		chk("irq", 32'h1, 32'(irq));
		wb(1'b1, 8'h04, 32'h8);
		settle;
		chk("irq", 32'h0, 32'(irq));
		wb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h0, q);
		$display("t_irq finished");
	endtask : t_irq

	// Cuts a hung run short.
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_total++;
			$display("[ERR] run_cycles expected below 20000 seen %0d", cyc_n);
			summarize;
		end
	end

	// Reset for 20 cycles, then the scenarios.
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
		fault = 4'hf;
		err_total = 0;
		cmp_count = 0;
		cyc_n = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_slots;
		t_spare;
		t_count;
		t_irq;
		summarize;
	end
endmodule : fsa_top_bench
